// ===== hdl/sds_div.sv
// Purpose: Programmable down-counting divider with wrap pulse
// Assumes: tick is a one-cycle enable in the clk_sys domain
// Notes: Period is ratio ticks; restart reloads the ratio at once
`timescale 1ns/10ps
module sds_div #(
  parameter int WIDTH = 11
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Control
  input wire logic restart,
  input wire logic tick,
  input wire logic [WIDTH-1:0] ratio,
  // Status
  output logic [WIDTH-1:0] count,
  output logic wrap
);

  // ********************************************************
  // Counter
  // ********************************************************
  logic [WIDTH-1:0] cnt_reg;
  logic wrap_reg;

  // A one-bit counter cannot hold a ratio above one
  if (WIDTH < 2) begin : g_bad_width
    $error("sds_div: counter width must be at least 2");
  end

  // Count down, reload at one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      wrap_reg <= 1'b0;
    end else if (restart) begin
      cnt_reg <= ratio;
      wrap_reg <= 1'b0;
    end else if (tick) begin
      if (cnt_reg <= WIDTH'(1)) begin
        cnt_reg <= ratio;
        wrap_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - WIDTH'(1);
        wrap_reg <= 1'b0;
      end
    end else begin
      wrap_reg <= 1'b0;
    end
  end

  assign count = cnt_reg;
  assign wrap = wrap_reg;

endmodule

// ===== hdl/sds_pkg.sv
// Purpose: Shared constants for the serial-programmed synthesiser dividers
// Assumes: One system clock; all pins synchronous to it
// Notes: Register offsets are byte addresses on the AXI4-Lite slave
package sds_pkg;

  // ********************************************************
  // Word widths of the serial stream, edge count and bus address
  // ********************************************************
  localparam int SDS_SWAL_W = 7;
  localparam int SDS_MAIN_W = 10;
  localparam int SDS_BAND_W = 2;
  localparam int SDS_REF_W = 11;
  localparam int SDS_FULL_BITS = 30;
  localparam int SDS_CNT_W = 5;
  localparam int SDS_ADDR_W = 8;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] SDS_OFS_CTRL = 8'h00;
  localparam logic [7:0] SDS_OFS_STATUS = 8'h04;
  localparam logic [7:0] SDS_OFS_SWAL = 8'h08;
  localparam logic [7:0] SDS_OFS_MAIN = 8'h0c;
  localparam logic [7:0] SDS_OFS_BAND = 8'h10;
  localparam logic [7:0] SDS_OFS_REF = 8'h14;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int SDS_CTRL_RUN_BIT = 0;
  localparam int SDS_ST_FULL_BIT = 8;
  localparam int SDS_ST_EN_BIT = 9;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic SDS_CTRL_RUN_RST = 1'b1;
  localparam logic [6:0] SDS_SWAL_RST = 7'h00;
  localparam logic [9:0] SDS_MAIN_RST = 10'h008;
  localparam logic [1:0] SDS_BAND_RST = 2'h0;
  localparam logic [10:0] SDS_REF_RST = 11'h003;

  // ********************************************************
  // Bus responses
  // ********************************************************
  localparam logic [1:0] SDS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDS_RESP_DECERR = 2'h3;

  // Commit sequence after an enable fall
  typedef enum logic [1:0] {
    SDS_LD_IDLE = 2'b00,
    SDS_LD_SYNC = 2'b01
  } sds_ld_state_t;

endpackage

// ===== hdl/sds_synth.sv
// Purpose: Serial load port, reference divider and dual-modulus counters
// Assumes: Serial pins, oscillator and prescaler inputs synchronous to clk_sys
// Notes: Registers on AXI4-Lite mirror the latched words and load state
// Notes on behaviour
// RULE_01: Data high means one, low means zero
// RULE_02: Stream order swallow, main, band, reference, MSB first
// RULE_03: Shift data on each serial clock fall
// RULE_04: Short load keeps reference latch unchanged
// RULE_05: Thirty edges also load the reference latch
// RULE_06: Data and clock ignored while enable low
// RULE_07: Enable fall latches words and resyncs dividers
// RULE_08: Modulus select low until swallow count done
// RULE_09: Then high until main count done, restart
// RULE_10: Swallow count programmable zero to 127
// RULE_11: Main count programmable eight to 1023
// RULE_12: Host keeps main count not below swallow
// RULE_13: Reference ratio 3 to 2047, then halved
// RULE_14: Band outputs show latched band word
// RULE_15: Host raises enable, clocks bits, drops enable
// RULE_16: Count serial falls, clear on enable rise
// RULE_17: Short load also latches the band word
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module sds_synth
  import sds_pkg::*;
#(
  parameter int SWAL_W = sds_pkg::SDS_SWAL_W,
  parameter int MAIN_W = sds_pkg::SDS_MAIN_W,
  parameter int BAND_W = sds_pkg::SDS_BAND_W,
  parameter int REF_W = sds_pkg::SDS_REF_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Serial load port
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_enable,
  // Divider inputs
  input wire logic osc_in,
  input wire logic pres_in,
  // Divider outputs
  output logic prescaler_select_out,
  output logic ref_div_out,
  output logic main_div_out,
  output logic [BAND_W-1:0] band_out,
  // AXI4-Lite write channels
  input wire logic [sds_pkg::SDS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [sds_pkg::SDS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sds_pkg::*;

  localparam int PART_BITS = SWAL_W + MAIN_W + BAND_W;
  localparam int FULL_BITS = PART_BITS + REF_W;

  // Refuse widths the stream layout cannot serve
  if (FULL_BITS != SDS_FULL_BITS || SWAL_W > 31 || MAIN_W > 31 || REF_W > 31) begin : g_bad_width
    $error("sds_synth: word widths do not match the 30-bit stream");
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction

  // ********************************************************
  // Edge detection of pins
  // ********************************************************
  logic ser_clk_d_reg;
  logic ser_en_d_reg;
  logic osc_d_reg;
  logic pres_d_reg;
  logic shift_en;
  logic en_rise;
  logic en_fall;
  logic run_reg;
  logic ref_tick;
  logic main_tick;

  // Previous pin levels
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ser_clk_d_reg <= 1'b0;
      ser_en_d_reg <= 1'b0;
      osc_d_reg <= 1'b0;
      pres_d_reg <= 1'b0;
    end else begin
      ser_clk_d_reg <= ser_clk;
      ser_en_d_reg <= ser_enable;
      osc_d_reg <= osc_in;
      pres_d_reg <= pres_in;
    end
  end

  // Shifting gated by enable
  assign shift_en = fell(ser_clk_d_reg, ser_clk) & ser_enable; // RULE_06
  assign en_rise = rose(ser_en_d_reg, ser_enable);
  assign en_fall = fell(ser_en_d_reg, ser_enable);
  assign ref_tick = rose(osc_d_reg, osc_in) & run_reg;
  assign main_tick = rose(pres_d_reg, pres_in) & run_reg;

  // ********************************************************
  // Shift register and edge count
  // ********************************************************
  logic [FULL_BITS-1:0] shift_reg;
  logic [SDS_CNT_W-1:0] bit_cnt_reg;

  // Serial bit enters at the low end, MSB first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= '0;
    end else if (shift_en) begin
      shift_reg <= {shift_reg[FULL_BITS-2:0], ser_data}; // RULE_03 RULE_01
    end
  end

  // Saturating count of accepted clock falls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= '0;
    end else if (en_rise) begin
      bit_cnt_reg <= '0; // RULE_16
    end else if (shift_en && bit_cnt_reg != '1) begin
      bit_cnt_reg <= bit_cnt_reg + SDS_CNT_W'(1); // RULE_16
    end
  end

  // ********************************************************
  // Word selection and latches
  // ********************************************************
  logic full_load;
  logic [SWAL_W-1:0] swal_next;
  logic [MAIN_W-1:0] main_next;
  logic [BAND_W-1:0] band_next;
  logic [SWAL_W-1:0] swal_reg;
  logic [MAIN_W-1:0] main_reg;
  logic [BAND_W-1:0] band_reg;
  logic [REF_W-1:0] ref_reg;
  logic last_full_reg;

  assign full_load = bit_cnt_reg >= SDS_CNT_W'(FULL_BITS);

  // Word positions depend on how many bits went in
  always_comb begin
    if (full_load) begin
      swal_next = shift_reg[FULL_BITS-1 -: SWAL_W]; // RULE_02
      main_next = shift_reg[FULL_BITS-1-SWAL_W -: MAIN_W];
      band_next = shift_reg[REF_W+BAND_W-1 -: BAND_W];
    end else begin
      swal_next = shift_reg[PART_BITS-1 -: SWAL_W]; // RULE_02
      main_next = shift_reg[PART_BITS-1-SWAL_W -: MAIN_W];
      band_next = shift_reg[BAND_W-1:0];
    end
  end

  // Commit on enable fall
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      swal_reg <= SWAL_W'(SDS_SWAL_RST);
      main_reg <= MAIN_W'(SDS_MAIN_RST);
      band_reg <= BAND_W'(SDS_BAND_RST);
      ref_reg <= REF_W'(SDS_REF_RST);
      last_full_reg <= 1'b0;
    end else if (en_fall) begin
      swal_reg <= swal_next; // RULE_07 RULE_10
      main_reg <= main_next; // RULE_07 RULE_11
      band_reg <= band_next; // RULE_17 RULE_14
      last_full_reg <= full_load;
      if (full_load) begin // RULE_04
        ref_reg <= shift_reg[REF_W-1:0]; // RULE_05
      end
    end
  end

  assign band_out = band_reg; // RULE_14

  // ********************************************************
  // Resynchronisation after commit
  // ********************************************************
  sds_ld_state_t ld_state_reg;
  logic resync;

  // One cycle later the new ratios are in place
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ld_state_reg <= SDS_LD_IDLE;
    end else begin
      case (ld_state_reg)
        SDS_LD_IDLE: begin
          if (en_fall) begin
            ld_state_reg <= SDS_LD_SYNC;
          end
        end
        SDS_LD_SYNC: begin
          ld_state_reg <= en_fall ? SDS_LD_SYNC : SDS_LD_IDLE;
        end
        default: begin
          ld_state_reg <= SDS_LD_IDLE;
        end
      endcase
    end
  end

  assign resync = ld_state_reg == SDS_LD_SYNC; // RULE_07

  // ********************************************************
  // Reference divider and divide-by-two
  // ********************************************************
  logic ref_wrap;
  logic ref_out_reg;

  sds_div #(.WIDTH(REF_W)) u_ref_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .restart(resync),
    .tick(ref_tick),
    .ratio(ref_reg),
    .count(),
    .wrap(ref_wrap)
  );

  // Toggle halves the divided rate
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ref_out_reg <= 1'b0;
    end else if (resync) begin
      ref_out_reg <= 1'b0; // RULE_07
    end else if (ref_wrap) begin
      ref_out_reg <= ~ref_out_reg; // RULE_13
    end
  end

  assign ref_div_out = ref_out_reg;

  // ********************************************************
  // Main and swallow counters
  // ********************************************************
  logic main_wrap;
  logic [MAIN_W-1:0] main_count;
  logic main_last;
  logic main_out_reg;
  logic [SWAL_W-1:0] swal_left_reg;
  logic mod_sel_reg;

  sds_div #(.WIDTH(MAIN_W)) u_main_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .restart(resync),
    .tick(main_tick),
    .ratio(main_reg),
    .count(main_count),
    .wrap(main_wrap)
  );

  assign main_last = main_count <= MAIN_W'(1);

  // Main divider output, realigned with the reference
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      main_out_reg <= 1'b0;
    end else if (resync) begin
      main_out_reg <= 1'b0; // RULE_07
    end else if (main_wrap) begin
      main_out_reg <= ~main_out_reg;
    end
  end

  assign main_div_out = main_out_reg;

  // Swallow phase then main phase of each cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      swal_left_reg <= '0;
      mod_sel_reg <= 1'b0;
    end else if (resync || (main_tick && main_last)) begin
      swal_left_reg <= swal_reg; // RULE_09
      mod_sel_reg <= swal_reg == '0; // RULE_08
    end else if (main_tick && swal_left_reg == SWAL_W'(1)) begin
      swal_left_reg <= '0;
      mod_sel_reg <= 1'b1; // RULE_09
    end else if (main_tick && swal_left_reg != '0) begin
      swal_left_reg <= swal_left_reg - SWAL_W'(1); // RULE_08
    end
  end

  assign prescaler_select_out = mod_sel_reg;

  // ********************************************************
  // AXI4-Lite slave
  // ********************************************************
  logic awready_reg;
  logic wready_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [SDS_ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_do;
  logic [31:0] rd_word;
  logic rd_hit;

  assign wr_do = aw_got_reg && w_got_reg && !bvalid_reg;

  // Write address capture
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      awready_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      waddr_reg <= '0;
    end else if (s_axi_awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_got_reg <= 1'b1;
      waddr_reg <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_got_reg <= 1'b0;
    end else if (!aw_got_reg && !bvalid_reg) begin
      awready_reg <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wready_reg <= 1'b0;
      w_got_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_got_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (wr_do) begin
      w_got_reg <= 1'b0;
    end else if (!w_got_reg && !bvalid_reg) begin
      wready_reg <= 1'b1;
    end
  end

  // Write response and control register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= SDS_RESP_OKAY;
      run_reg <= SDS_CTRL_RUN_RST;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= SDS_RESP_OKAY;
      if ({waddr_reg[SDS_ADDR_W-1:2], 2'b00} == SDS_OFS_CTRL) begin
        if (wstrb0_reg) begin
          run_reg <= wdata_reg[SDS_CTRL_RUN_BIT];
        end
      end else if ({waddr_reg[SDS_ADDR_W-1:2], 2'b00} > SDS_OFS_REF) begin
        bresp_reg <= SDS_RESP_DECERR;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read decode
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case ({s_axi_araddr[SDS_ADDR_W-1:2], 2'b00})
      SDS_OFS_CTRL: rd_word[SDS_CTRL_RUN_BIT] = run_reg;
      SDS_OFS_STATUS: begin
        rd_word[SDS_CNT_W-1:0] = bit_cnt_reg;
        rd_word[SDS_ST_FULL_BIT] = last_full_reg;
        rd_word[SDS_ST_EN_BIT] = ser_en_d_reg;
      end
      SDS_OFS_SWAL: rd_word[SWAL_W-1:0] = swal_reg;
      SDS_OFS_MAIN: rd_word[MAIN_W-1:0] = main_reg;
      SDS_OFS_BAND: rd_word[BAND_W-1:0] = band_reg;
      SDS_OFS_REF: rd_word[REF_W-1:0] = ref_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= SDS_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? SDS_RESP_OKAY : SDS_RESP_DECERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ********************************************************
  // Checks
  // ********************************************************
  a_shift_bit: // RULE_03
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      shift_en |=> shift_reg[0] == $past(ser_data) && shift_reg[FULL_BITS-1:1] == $past(shift_reg[FULL_BITS-2:0]))
    else $error("serial bit not shifted on clock fall");

  a_idle_ignored: // RULE_06
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      !ser_enable |=> $stable(shift_reg))
    else $error("shift register moved while enable low");

  a_count_clear: // RULE_16
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      en_rise |=> bit_cnt_reg == '0)
    else $error("edge count not cleared on enable rise");

  a_partial_ref: // RULE_04
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      en_fall && bit_cnt_reg < SDS_CNT_W'(FULL_BITS) |=> $stable(ref_reg))
    else $error("reference latch changed on short load");

  a_full_ref: // RULE_05
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      en_fall && bit_cnt_reg >= SDS_CNT_W'(FULL_BITS) |=> ref_reg == $past(shift_reg[REF_W-1:0]))
    else $error("reference latch not loaded on full load");

  a_commit_words: // RULE_07
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      en_fall |=> swal_reg == $past(swal_next) && main_reg == $past(main_next) && band_out == $past(band_next))
    else $error("words not committed on enable fall");

  a_resync_outs: // RULE_07
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      en_fall |-> ##2 !ref_div_out && !main_div_out && swal_left_reg == swal_reg)
    else $error("dividers not realigned after commit");

  a_sel_low_start: // RULE_08
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      main_tick && main_last && !resync && swal_reg != '0 |=> !prescaler_select_out)
    else $error("modulus select not low at cycle start");

  a_sel_high_after: // RULE_09
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      main_tick && !main_last && !resync && swal_left_reg == SWAL_W'(1) |=> prescaler_select_out)
    else $error("modulus select not high after swallow phase");

  a_ref_half: // RULE_13
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      ref_wrap && !resync |=> ref_div_out != $past(ref_div_out))
    else $error("reference output did not toggle on wrap");

endmodule

// ===== tb/sds_host_model.sv
// Purpose: Host and prescaler model driving the serial port
// Assumes: All pins change just after a clk_sys rise
// Notes: ser_clk idles high; data shows the inverse between frames
`timescale 1ns/10ps
module sds_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial and divider pins
  output logic ser_data,
  output logic ser_clk,
  output logic ser_enable,
  output logic osc_in,
  output logic pres_in
);
  initial begin
    ser_data = 1'b0;
    ser_clk = 1'b1;
    ser_enable = 1'b0;
    osc_in = 1'b0;
    pres_in = 1'b0;
  end

  // Load n bits MSB first, then commit
  task automatic load(input logic [29:0] w, input int n);
    @(posedge clk_sys);
    ser_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = n - 1; i >= 0; i--) begin
      ser_data <= w[i];
      ser_clk <= 1'b1;
      @(posedge clk_sys);
      ser_clk <= 1'b0;
      @(posedge clk_sys);
    end
    ser_clk <= 1'b1;
    @(posedge clk_sys);
    ser_enable <= 1'b0;
    ser_data <= ~ser_data;
    repeat (4) @(posedge clk_sys);
  endtask

  // Clock falls with enable low
  task automatic idle_clk(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ser_clk <= 1'b0;
      ser_data <= ~ser_data;
      @(posedge clk_sys);
      ser_clk <= 1'b1;
    end
  endtask

  // Rising edges on oscillator (sel 0) or prescaler (sel 1)
  task automatic pulse(input logic sel, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (sel) pres_in <= 1'b1;
      else osc_in <= 1'b1;
      @(posedge clk_sys);
      pres_in <= 1'b0;
      osc_in <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the synthesiser dividers
// Assumes: AXI4-Lite master here, serial host in the model
// Notes: Expected values come from the loaded words
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import sds_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ser_data, ser_clk, ser_enable, osc_in, pres_in;
  logic prescaler_select_out, ref_div_out, main_div_out;
  logic [1:0] band_out, bresp, rresp;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] r;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] ofs [5] = '{SDS_OFS_CTRL, SDS_OFS_SWAL, SDS_OFS_MAIN, SDS_OFS_BAND, SDS_OFS_REF};
  logic [31:0] rst_v [5] = '{32'h1, 32'h0, 32'h8, 32'h0, 32'h3};

  always #12.5 clk_sys = ~clk_sys;

  sds_host_model i_sds_host_model (.clk_sys(clk_sys), .ser_data(ser_data), .ser_clk(ser_clk),
    .ser_enable(ser_enable), .osc_in(osc_in), .pres_in(pres_in));

  sds_synth i_sds_synth (.clk_sys(clk_sys), .rst_b(rst_b), .ser_data(ser_data), .ser_clk(ser_clk),
    .ser_enable(ser_enable), .osc_in(osc_in), .pres_in(pres_in),
    .prescaler_select_out(prescaler_select_out), .ref_div_out(ref_div_out),
    .main_div_out(main_div_out), .band_out(band_out), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // AXI4-Lite read of one word
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    dat = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // AXI4-Lite write of one word
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dat;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge clk_sys);
      if (aw_open && awready === 1'b1) begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready === 1'b1) begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_sys);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    // Reset values and an unmapped read
    foreach (ofs[i]) begin
      rd(ofs[i], d, r);
      `CHK(d, rst_v[i])
    end
    rd(8'h18, d, r);
    `CHK(r, SDS_RESP_DECERR)
    // Full load A=5 M=9 B=2 R=4
    i_sds_host_model.load({7'd5, 10'd9, 2'd2, 11'd4}, 30);
    rd(SDS_OFS_SWAL, d, r);
    `CHK(d, 32'h5)
    rd(SDS_OFS_MAIN, d, r);
    `CHK(d, 32'h9)
    rd(SDS_OFS_REF, d, r);
    `CHK(d, 32'h4)
    rd(SDS_OFS_STATUS, d, r);
    `CHK(d[9:0], 10'h11e)
    `CHK(band_out, 2'h2)
    `CHK(ref_div_out, 1'b0)
    `CHK(prescaler_select_out, 1'b0)
    // Reference divider, halted then running
    wr(SDS_OFS_CTRL, 32'h0, r);
    i_sds_host_model.pulse(1'b0, 4);
    `CHK(ref_div_out, 1'b0)
    wr(SDS_OFS_CTRL, 32'h1, r);
    i_sds_host_model.pulse(1'b0, 3);
    `CHK(ref_div_out, 1'b0)
    i_sds_host_model.pulse(1'b0, 1);
    `CHK(ref_div_out, 1'b1)
    wr(8'h20, 32'h0, r);
    `CHK(r, SDS_RESP_DECERR)
    // Short load A=3 M=12 B=1, main not below swallow
    i_sds_host_model.load({11'h0, 7'd3, 10'd12, 2'd1}, 19);
    rd(SDS_OFS_REF, d, r);
    `CHK(d, 32'h4)
    rd(SDS_OFS_SWAL, d, r);
    `CHK(d, 32'h3)
    rd(SDS_OFS_MAIN, d, r);
    `CHK(d, 32'hc)
    `CHK(band_out, 2'h1)
    // Clock falls with enable low
    i_sds_host_model.idle_clk(5);
    rd(SDS_OFS_STATUS, d, r);
    `CHK(d[9:0], 10'h013)
    rd(SDS_OFS_SWAL, d, r);
    `CHK(d, 32'h3)
    // Dual-modulus cycle of M=12, A=3
    i_sds_host_model.pulse(1'b1, 2);
    `CHK(prescaler_select_out, 1'b0)
    i_sds_host_model.pulse(1'b1, 1);
    `CHK(prescaler_select_out, 1'b1)
    i_sds_host_model.pulse(1'b1, 8);
    `CHK(main_div_out, 1'b0)
    `CHK(prescaler_select_out, 1'b1)
    i_sds_host_model.pulse(1'b1, 1);
    `CHK(main_div_out, 1'b1)
    `CHK(prescaler_select_out, 1'b0)
    // Swallow of zero keeps the select high all cycle, M=8 B=3
    i_sds_host_model.load({11'h0, 7'd0, 10'd8, 2'd3}, 19);
    `CHK(prescaler_select_out, 1'b1)
    `CHK(band_out, 2'h3)
    i_sds_host_model.pulse(1'b1, 8);
    `CHK(main_div_out, 1'b1)
    `CHK(prescaler_select_out, 1'b1)
    print_verdict();
  end
endmodule
